// ### verilog/asc_pkg.sv
// constants, bus carrier and state type for the converter cpu_free_conversion_mode/result control
package asc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing at the system clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAB_TIME_NS = 1000;
  localparam int SAMPLE_TIME_NS = 700;
  localparam int CONV_TIME_NS = 2700;
  // least times, rounded up; conversion time includes the sampling interval
  localparam int STAB_CYC = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // result format: 10 bits, one step is 1/1024 of full scale
  localparam int RES_BITS = 10;
  localparam int CODE_STEPS = 1024;
  localparam int SCAN_CHANNELS = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [3:0] A_MODE0 = 4'h0;
  localparam logic [3:0] A_MODE1 = 4'h1;
  localparam logic [3:0] A_MODE2 = 4'h2;
  localparam logic [3:0] A_CHSEL = 4'h3;
  localparam logic [3:0] A_PORTCFG = 4'h4;
  localparam logic [3:0] A_UPPER = 4'h5;
  localparam logic [3:0] A_LOWER = 4'h6;
  localparam logic [3:0] A_RES_LO = 4'h7;
  localparam logic [3:0] A_RES_HI = 4'h8;
  localparam logic [3:0] A_FLAGS = 4'h9;

  // field positions
  localparam int B_RUN = 7;
  localparam int B_SCAN = 6;
  localparam int B_CMP_EN = 0;
  localparam int B_TRIG_SEL = 0;
  localparam int B_WAKE = 2;
  localparam int B_RCHK = 3;
  localparam int B_DONE = 0;

  // values after reset
  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [7:0] MODE1_RST = 8'h00;
  localparam logic [7:0] MODE2_RST = 8'h00;
  localparam logic [7:0] CHSEL_RST = 8'h00;
  localparam logic [7:0] PORTCFG_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } asc_bus_s;

  typedef enum logic [1:0] {ST_IDLE, ST_STAB, ST_CONV} asc_state_e;

endpackage

// ### verilog/asc_conv_seq.sv
// conversion sequencer: sampling then conversion, result captured at the end
`timescale 1ns/1ns
`default_nettype none
module asc_conv_seq
#(
  parameter int SAMPLE_CYC = asc_pkg::SAMPLE_CYC,
  parameter int CONV_CYC = asc_pkg::CONV_CYC,
  parameter int RES_BITS = asc_pkg::RES_BITS
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [RES_BITS-1:0] i_code,
  // status
  output logic o_busy,
  output logic o_sample,
  output logic o_done,
  output logic [RES_BITS-1:0] o_code
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] CONV_LOAD = CW'(CONV_CYC);
  localparam logic [CW-1:0] SAMPLE_END = CW'(CONV_CYC - SAMPLE_CYC);
  logic [CW-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // a start beats an abort, so a retrigger restarts cleanly
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      cnt_r <= '0;
    else if (i_start)
      cnt_r <= CONV_LOAD;
    else if (i_abort)
      cnt_r <= '0;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_done <= 1'b0;
      o_code <= '0;
    end
    else
    begin
      o_done <= (cnt_r == CW'(1)) && !i_start && !i_abort;
      if ((cnt_r == CW'(1)) && !i_start && !i_abort)
        o_code <= i_code;
    end
  end

  assign o_busy = (cnt_r != '0);
  assign o_sample = (cnt_r > SAMPLE_END);

endmodule
`default_nettype wire

// ### verilog/asc_cpu_free_conversion_mode_ctrl.sv
// converter control: wake conversion, clock request, range check, result arbitration
`timescale 1ns/1ns
`default_nettype none
module asc_cpu_free_conversion_mode_ctrl
#(
  parameter int RES_BITS = asc_pkg::RES_BITS
)
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  // register port
  input wire asc_pkg::asc_bus_s I_BUS,
  output logic [7:0] O_RDATA,
  // triggers, core state, analog side
  input wire logic I_CAL_TMR_IRQ,
  input wire logic I_INT_TMR_IRQ,
  input wire logic I_DEEP_STANDBY,
  input wire logic [RES_BITS-1:0] I_ANALOG_CODE,
  // status and control out
  output logic O_OSC_CLK_REQ,
  output logic O_CONV_DONE_IRQ,
  output logic O_WAKE_ACTIVE,
  output logic O_CMP_POWER,
  output logic O_SAMPLE,
  output logic [4:0] O_CHANNEL
);
  localparam int STAB_W = $clog2(asc_pkg::STAB_CYC + 1);
  localparam logic [STAB_W-1:0] STAB_LOAD = STAB_W'(asc_pkg::STAB_CYC - 1);
  localparam logic [1:0] LAST_SCAN = 2'(asc_pkg::SCAN_CHANNELS - 1);

  asc_pkg::asc_state_e state_r;
  logic [7:0] mode0_r, mode1_r, mode2_r, chsel_r, portcfg_r, upper_r, lower_r;
  logic [RES_BITS-1:0] result_r, pend_code_r, seq_code;
  logic [STAB_W-1:0] stab_cnt_r;
  logic [1:0] ch_idx_r;
  logic run_r, clk_req_r, wake_act_r, any_irq_r, pend_r, irq_r, done_flag_r;
  logic seq_done, seq_sample, trig, hw_trig, wake_go, wr_mode0, wr_chsel, wr_portcfg;
  logic cfg_wr, sw_stop, sw_start, hw_restart, stab_end, last_ch, next_ch;
  logic start_c, abort_c, in_range, irq_ok, res_rd, wr_flags, scan;
  logic [7:0] hi8, rd_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // decode and sequencing terms
  always_comb
  begin
    scan = mode0_r[asc_pkg::B_SCAN];
    trig = mode1_r[asc_pkg::B_TRIG_SEL] ? I_INT_TMR_IRQ : I_CAL_TMR_IRQ;
    hw_trig = trig && mode0_r[asc_pkg::B_CMP_EN];
    wake_go = hw_trig && mode2_r[asc_pkg::B_WAKE] && I_DEEP_STANDBY
              && (state_r == asc_pkg::ST_IDLE) && !clk_req_r;
    wr_mode0 = I_BUS.wr && (I_BUS.addr == asc_pkg::A_MODE0);
    wr_chsel = I_BUS.wr && (I_BUS.addr == asc_pkg::A_CHSEL);
    wr_portcfg = I_BUS.wr && (I_BUS.addr == asc_pkg::A_PORTCFG);
    wr_flags = I_BUS.wr && (I_BUS.addr == asc_pkg::A_FLAGS);
    cfg_wr = wr_mode0 || wr_chsel || wr_portcfg;
    res_rd = I_BUS.rd && ((I_BUS.addr == asc_pkg::A_RES_LO)
                          || (I_BUS.addr == asc_pkg::A_RES_HI));
    sw_stop = wr_mode0 && !I_BUS.wdata[asc_pkg::B_RUN];
    sw_start = wr_mode0 && I_BUS.wdata[asc_pkg::B_RUN] && I_BUS.wdata[asc_pkg::B_CMP_EN];
    // in standby without the wake path the converter has no clock: ignore triggers
    hw_restart = hw_trig && !wake_go && (state_r != asc_pkg::ST_STAB)
                 && (!I_DEEP_STANDBY || clk_req_r);
    stab_end = (state_r == asc_pkg::ST_STAB) && (stab_cnt_r == '0);
    last_ch = !scan || (ch_idx_r == LAST_SCAN);
    next_ch = seq_done && (state_r == asc_pkg::ST_CONV) && !last_ch && !wr_chsel;
    start_c = (hw_restart || sw_start || stab_end || next_ch) && !sw_stop;
    abort_c = (sw_stop && run_r) || (wr_chsel && (state_r == asc_pkg::ST_CONV));
    // limits compare against the upper eight bits of the result
    hi8 = seq_code[RES_BITS-1 -: 8];
    in_range = (hi8 >= lower_r) && (hi8 <= upper_r);
    irq_ok = seq_done && (state_r == asc_pkg::ST_CONV) && !cfg_wr
             && (mode2_r[asc_pkg::B_RCHK] ? !in_range : in_range);
  end

  asc_conv_seq
  #(
    .RES_BITS(RES_BITS)
  )
  i_asc_conv_seq
  (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .i_start(start_c),
    .i_abort(abort_c),
    .i_code(I_ANALOG_CODE),
    .o_busy(),
    .o_sample(seq_sample),
    .o_done(seq_done),
    .o_code(seq_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // conversion state, clock request and wake bookkeeping
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      state_r <= asc_pkg::ST_IDLE;
      stab_cnt_r <= '0;
      ch_idx_r <= 2'h0;
      run_r <= 1'b0;
      clk_req_r <= 1'b0;
      wake_act_r <= 1'b0;
      any_irq_r <= 1'b0;
    end
    else
    begin
      if (abort_c && !start_c)
      begin
        state_r <= asc_pkg::ST_IDLE;
        run_r <= 1'b0;
        if (wake_act_r)
        begin
          clk_req_r <= 1'b0;
          wake_act_r <= 1'b0;
        end
      end
      else if (start_c)
      begin
        state_r <= asc_pkg::ST_CONV;
        run_r <= 1'b1;
        ch_idx_r <= next_ch ? ch_idx_r + 2'h1 : 2'h0;
        any_irq_r <= next_ch && (any_irq_r || irq_ok);
      end
      else if (wake_go)
      begin
        state_r <= asc_pkg::ST_STAB;
        clk_req_r <= 1'b1;
        wake_act_r <= 1'b1;
        stab_cnt_r <= STAB_LOAD;
      end
      else if (state_r == asc_pkg::ST_STAB)
        stab_cnt_r <= stab_cnt_r - 1'b1;
      else if ((state_r == asc_pkg::ST_CONV) && seq_done)
      begin
        state_r <= asc_pkg::ST_IDLE;
        run_r <= 1'b0;
        wake_act_r <= 1'b0;
        if (wake_act_r && !(any_irq_r || irq_ok))
          clk_req_r <= 1'b0;
      end
      // after a wake that went normal, the request ends when wake is disabled
      if (I_BUS.wr && (I_BUS.addr == asc_pkg::A_MODE2)
          && !I_BUS.wdata[asc_pkg::B_WAKE] && !wake_act_r && !wake_go)
        clk_req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result word, held-back write, interrupt pulse and done flag
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      result_r <= '0;
      pend_r <= 1'b0;
      pend_code_r <= '0;
    end
    else if (irq_ok && res_rd)
    begin
      pend_r <= 1'b1;
      pend_code_r <= seq_code;
    end
    else if (irq_ok)
    begin
      result_r <= seq_code;
      pend_r <= 1'b0;
    end
    else if (pend_r && !res_rd)
    begin
      result_r <= pend_code_r;
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      irq_r <= 1'b0;
      done_flag_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_ok;
      // a hardware set in the clearing cycle wins
      done_flag_r <= irq_ok
                     || (done_flag_r && !(wr_flags && !I_BUS.wdata[asc_pkg::B_DONE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes and read port
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      mode0_r <= asc_pkg::MODE0_RST;
      mode1_r <= asc_pkg::MODE1_RST;
      mode2_r <= asc_pkg::MODE2_RST;
      chsel_r <= asc_pkg::CHSEL_RST;
      portcfg_r <= asc_pkg::PORTCFG_RST;
      upper_r <= asc_pkg::UPPER_RST;
      lower_r <= asc_pkg::LOWER_RST;
    end
    else if (I_BUS.wr)
    begin
      case (I_BUS.addr)
        asc_pkg::A_MODE0: mode0_r <= I_BUS.wdata;
        asc_pkg::A_MODE1: mode1_r <= I_BUS.wdata;
        asc_pkg::A_MODE2: mode2_r <= I_BUS.wdata;
        asc_pkg::A_CHSEL: chsel_r <= I_BUS.wdata;
        asc_pkg::A_PORTCFG: portcfg_r <= I_BUS.wdata;
        asc_pkg::A_UPPER: upper_r <= I_BUS.wdata;
        asc_pkg::A_LOWER: lower_r <= I_BUS.wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (I_BUS.addr)
      asc_pkg::A_MODE0: rd_nxt = {run_r, mode0_r[6:0]};
      asc_pkg::A_MODE1: rd_nxt = mode1_r;
      asc_pkg::A_MODE2: rd_nxt = mode2_r;
      asc_pkg::A_CHSEL: rd_nxt = chsel_r;
      asc_pkg::A_PORTCFG: rd_nxt = portcfg_r;
      asc_pkg::A_UPPER: rd_nxt = upper_r;
      asc_pkg::A_LOWER: rd_nxt = lower_r;
      asc_pkg::A_RES_LO: rd_nxt = {result_r[1:0], 6'h00};
      asc_pkg::A_RES_HI: rd_nxt = result_r[RES_BITS-1 -: 8];
      asc_pkg::A_FLAGS: rd_nxt = {7'h00, done_flag_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
      O_RDATA <= 8'h00;
    else
      O_RDATA <= I_BUS.rd ? rd_nxt : 8'h00;
  end

  assign O_OSC_CLK_REQ = clk_req_r;
  assign O_CONV_DONE_IRQ = irq_r;
  assign O_WAKE_ACTIVE = wake_act_r;
  assign O_CMP_POWER = mode0_r[asc_pkg::B_CMP_EN];
  assign O_SAMPLE = seq_sample;
  assign O_CHANNEL = chsel_r[4:0] + (scan ? {3'h0, ch_idx_r} : 5'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);

  sequence s_wake_end_quiet;
    // a trigger in the same cycle restarts the scan instead of ending it
    wake_act_r && seq_done && (state_r == asc_pkg::ST_CONV) && last_ch
      && !abort_c && !start_c && !(any_irq_r || irq_ok);
  endsequence

  sequence s_read_collide;
    irq_ok && res_rd;
  endsequence

  range_irq_block_a: assert property (
    (seq_done && !(mode2_r[asc_pkg::B_RCHK] ? !in_range : in_range)) |=> !O_CONV_DONE_IRQ)
    else $error("interrupt raised for a rejected result");
  quiet_clk_drop_a: assert property (
    s_wake_end_quiet |=> !O_OSC_CLK_REQ && (state_r == asc_pkg::ST_IDLE))
    else $error("clock request kept after a quiet wake conversion");
  scan_req_hold_a: assert property (
    (wake_act_r && scan && seq_done && !last_ch && !abort_c) |=> O_OSC_CLK_REQ)
    else $error("clock request dropped before the last scan channel");
  req_fall_idle_a: assert property (
    $fell(O_OSC_CLK_REQ) |-> (state_r == asc_pkg::ST_IDLE) && !wake_act_r)
    else $error("clock request fell while not back in standby");
  result_kept_a: assert property (
    (seq_done && !irq_ok && !pend_r) |=> $stable(result_r))
    else $error("result changed for a suppressed conversion");
  read_first_a: assert property (
    s_read_collide |=> pend_r && $stable(result_r))
    else $error("result written before the colliding read");
  pend_drain_a: assert property (
    (pend_r && !res_rd && !irq_ok) |=> !pend_r && (result_r == $past(pend_code_r)))
    else $error("held-back result not written after the read");
  cfg_write_wins_a: assert property (
    (seq_done && cfg_wr && !pend_r) |=> !O_CONV_DONE_IRQ && $stable(result_r))
    else $error("result stored despite a colliding register write");
  stab_then_conv_a: assert property (
    wake_go |=> O_OSC_CLK_REQ && (state_r == asc_pkg::ST_STAB))
    else $error("wake trigger did not start the stabilisation wait");
  scan_go_normal_a: assert property (
    (wake_act_r && seq_done && last_ch && !abort_c && !start_c && (any_irq_r || irq_ok))
      |=> O_OSC_CLK_REQ && !O_WAKE_ACTIVE)
    else $error("scan wake with an interrupt did not go normal");
  req_cause_a: assert property (
    $rose(O_OSC_CLK_REQ) |-> $past(wake_go))
    else $error("clock request raised without an enabled trigger");

endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the converter cpu_free_conversion_mode/result control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic I_CLK_SYS = 1'b0;
  logic I_SRST = 1'b1;
  asc_pkg::asc_bus_s I_BUS = '0;
  logic I_CAL_TMR_IRQ = 1'b0;
  logic I_INT_TMR_IRQ = 1'b0;
  logic I_DEEP_STANDBY = 1'b0;
  logic [9:0] I_ANALOG_CODE = 10'h000;
  logic [7:0] O_RDATA;
  logic O_OSC_CLK_REQ;
  logic O_CONV_DONE_IRQ;
  logic O_WAKE_ACTIVE;
  logic O_CMP_POWER;
  logic O_SAMPLE;
  logic [4:0] O_CHANNEL;
  int mismatches = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  int smp_cnt = 0;
  int seed = 32'h3e85;
  int t;
  int n_irq;
  int n_smp;
  logic rd_seen = 1'b0;
  logic smp_d = 1'b0;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [9:0] res_now;
  logic [7:0] rst_tab [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};

  always #50 I_CLK_SYS = ~I_CLK_SYS;

  asc_cpu_free_conversion_mode_ctrl i_asc_cpu_free_conversion_mode_ctrl (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_BUS(I_BUS), .O_RDATA(O_RDATA),
    .I_CAL_TMR_IRQ(I_CAL_TMR_IRQ), .I_INT_TMR_IRQ(I_INT_TMR_IRQ),
    .I_DEEP_STANDBY(I_DEEP_STANDBY), .I_ANALOG_CODE(I_ANALOG_CODE),
    .O_OSC_CLK_REQ(O_OSC_CLK_REQ), .O_CONV_DONE_IRQ(O_CONV_DONE_IRQ),
    .O_WAKE_ACTIVE(O_WAKE_ACTIVE), .O_CMP_POWER(O_CMP_POWER), .O_SAMPLE(O_SAMPLE),
    .O_CHANNEL(O_CHANNEL)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK_SYS);
    I_BUS <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge I_CLK_SYS);
    I_BUS <= '0;
  endtask

  // bit 8 of a note marks a read whose value is not judged
  task automatic rd(input logic [3:0] a, input logic [8:0] x);
    @(posedge I_CLK_SYS);
    I_BUS <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    exp_q.push_back(x);
    @(posedge I_CLK_SYS);
    I_BUS <= '0;
  endtask

  // back-to-back strobes on one address, covering the end of a conversion
  task automatic storm(input logic do_wr, input logic [3:0] a, input int n, input logic [8:0] x);
    repeat (n)
    begin
      @(posedge I_CLK_SYS);
      I_BUS <= '{wr: do_wr, rd: !do_wr, addr: a, wdata: 8'h00};
      if (!do_wr)
        exp_q.push_back(x);
    end
    @(posedge I_CLK_SYS);
    I_BUS <= '0;
  endtask

  task automatic rd_res(input logic [9:0] r);
    rd(asc_pkg::A_RES_HI, {1'b0, r[9:2]});
    rd(asc_pkg::A_RES_LO, {1'b0, r[1:0], 6'h00});
  endtask

  // pulse the chosen trigger, then wait for an interrupt or the request to fall
  task automatic run_wake(input logic use_int, output int n);
    n_irq = irq_cnt;
    n_smp = smp_cnt;
    @(posedge I_CLK_SYS);
    I_INT_TMR_IRQ <= use_int;
    I_CAL_TMR_IRQ <= !use_int;
    @(posedge I_CLK_SYS);
    I_INT_TMR_IRQ <= 1'b0;
    I_CAL_TMR_IRQ <= 1'b0;
    #1;
    check(O_OSC_CLK_REQ, 1'b1);
    n = 0;
    while (n < 400 && O_OSC_CLK_REQ === 1'b1 && irq_cnt == n_irq)
    begin
      @(posedge I_CLK_SYS);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge I_CLK_SYS)
  begin
    if (rd_seen)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0ff;
      if (!e[8])
        check(O_RDATA, e[7:0]);
    end
    rd_seen <= I_BUS.rd;
    if (O_CONV_DONE_IRQ === 1'b1)
      irq_cnt++;
    if (O_SAMPLE === 1'b1 && smp_d !== 1'b1)
      smp_cnt++;
    smp_d <= O_SAMPLE;
  end

  initial
  begin
    #(100 * 30000);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge I_CLK_SYS);
    I_SRST <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd((i == 10) ? 4'hf : i[3:0], {1'b0, rst_tab[i]});
    // software start with a read landing on every cycle of the conversion after its first
    res_now = 10'($random(seed));
    I_ANALOG_CODE <= res_now;
    n_irq = irq_cnt;
    wr(asc_pkg::A_MODE0, 8'h81);
    // the held-back write keeps every read of the storm on the reset result
    storm(1'b0, asc_pkg::A_RES_HI, asc_pkg::CONV_CYC + 12, 9'h000);
    repeat (10) @(posedge I_CLK_SYS);
    check(irq_cnt - n_irq, 1);
    rd_res(res_now);
    rd(asc_pkg::A_FLAGS, 9'h001);
    wr(asc_pkg::A_FLAGS, 8'h00);
    rd(asc_pkg::A_FLAGS, 9'h000);
    // register writes on every cycle: the result write must lose
    n_irq = irq_cnt;
    I_ANALOG_CODE <= ~res_now;
    wr(asc_pkg::A_MODE0, 8'h81);
    // rewrites keep the reset pin assignment, so no pin changes mid-conversion
    storm(1'b1, asc_pkg::A_PORTCFG, asc_pkg::CONV_CYC + 12, 9'h100);
    repeat (10) @(posedge I_CLK_SYS);
    check(irq_cnt - n_irq, 0);
    rd_res(res_now);
    wr(asc_pkg::A_MODE0, 8'h01);
    // standby trigger without wake enable is ignored
    I_DEEP_STANDBY <= 1'b1;
    @(posedge I_CLK_SYS);
    I_CAL_TMR_IRQ <= 1'b1;
    @(posedge I_CLK_SYS);
    I_CAL_TMR_IRQ <= 1'b0;
    repeat (20) @(posedge I_CLK_SYS);
    check(O_OSC_CLK_REQ, 1'b0);
    // single-channel wake, result inside the limits
    wr(asc_pkg::A_MODE2, 8'h04);
    res_now = 10'($random(seed));
    I_ANALOG_CODE <= res_now;
    run_wake(1'b0, t);
    check(irq_cnt - n_irq, 1);
    check(smp_cnt - n_smp, 1);
    check(t >= asc_pkg::STAB_CYC + asc_pkg::CONV_CYC - 2, 1);
    check(t <= asc_pkg::STAB_CYC + asc_pkg::CONV_CYC + 6, 1);
    check(O_OSC_CLK_REQ, 1'b1);
    rd_res(res_now);
    wr(asc_pkg::A_MODE2, 8'h00);
    repeat (3) @(posedge I_CLK_SYS);
    check(O_OSC_CLK_REQ, 1'b0);
    // single-channel wake, result above the upper limit, both trigger sources
    wr(asc_pkg::A_UPPER, 8'h3f);
    wr(asc_pkg::A_MODE2, 8'h04);
    for (int k = 0; k < 2; k++)
    begin
      I_ANALOG_CODE <= {2'b11, 8'($random(seed))};
      if (k == 1)
        wr(asc_pkg::A_MODE1, 8'h01);
      run_wake(k[0], t);
      repeat (5) @(posedge I_CLK_SYS);
      check(irq_cnt - n_irq, 0);
      check(O_OSC_CLK_REQ, 1'b0);
      check(t <= asc_pkg::STAB_CYC + asc_pkg::CONV_CYC + 6, 1);
      rd_res(res_now);
    end
    // four-channel scan wake, all quiet: request falls after the fourth channel
    wr(asc_pkg::A_MODE0, 8'h41);
    run_wake(1'b1, t);
    repeat (5) @(posedge I_CLK_SYS);
    check(t >= asc_pkg::STAB_CYC + 4 * asc_pkg::CONV_CYC - 2, 1);
    check(t <= asc_pkg::STAB_CYC + 4 * asc_pkg::CONV_CYC + 12, 1);
    check(smp_cnt - n_smp, asc_pkg::SCAN_CHANNELS);
    check(irq_cnt - n_irq, 0);
    check(O_OSC_CLK_REQ, 1'b0);
    // scan wake with polarity turned round: every channel interrupts
    wr(asc_pkg::A_MODE2, 8'h0c);
    run_wake(1'b1, t);
    check(O_CHANNEL, 5'h01);
    check(O_WAKE_ACTIVE, 1'b1);
    repeat (4 * asc_pkg::CONV_CYC) @(posedge I_CLK_SYS);
    check(irq_cnt - n_irq, asc_pkg::SCAN_CHANNELS);
    check(O_OSC_CLK_REQ, 1'b1);
    check(O_WAKE_ACTIVE, 1'b0);
    wr(asc_pkg::A_MODE2, 8'h00);
    repeat (3) @(posedge I_CLK_SYS);
    check(O_OSC_CLK_REQ, 1'b0);
    check(O_CMP_POWER, 1'b1);
    wr(asc_pkg::A_MODE0, 8'h00);
    repeat (2) @(posedge I_CLK_SYS);
    check(O_CMP_POWER, 1'b0);
    repeat (4) @(posedge I_CLK_SYS);
    wrap_up();
  end
endmodule
`default_nettype wire
